// ### inc/nvm_pkg.sv
// Package with register map, field positions and timing for the indirect memory access block
package nvm_pkg;
  // ****************************************************************
  // Register word offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [4:0] OFS_CONTROL = 5'h00; // Access control
  localparam logic [4:0] OFS_UNLOCK = 5'h04; // Unlock port, no storage
  localparam logic [4:0] OFS_ADDR_LO = 5'h08; // Address low byte
  localparam logic [4:0] OFS_ADDR_HI = 5'h0c; // Address high nibble
  localparam logic [4:0] OFS_DATA_LO = 5'h10; // Data low byte
  localparam logic [4:0] OFS_DATA_HI = 5'h14; // Data high bits
  localparam logic [4:0] OFS_IRQ_EN = 5'h18; // Peripheral interrupt enables
  localparam logic [4:0] OFS_IRQ_FLAG = 5'h1c; // Peripheral interrupt flags
  // ****************************************************************
  // Control register fields and interrupt flag/enable bit position
  // ****************************************************************
  localparam int BIT_RD = 0; // Read strobe
  localparam int BIT_WR = 1; // Write strobe
  localparam int BIT_WRITE_ENABLE_BIT = 2; // Write enable bit
  localparam int BIT_WRITE_ERROR_FLAG = 3; // Write error flag
  localparam int BIT_SEL = 7; // Memory select, 1 = program
  localparam int BIT_WCF = 7; // Write complete flag / enable position
  // ****************************************************************
  // Unlock key bytes and masks
  // ****************************************************************
  localparam logic [7:0] KEY_FIRST = 8'h55; // First unlock byte
  localparam logic [7:0] KEY_SECOND = 8'haa; // Second unlock byte
  localparam logic [7:0] MASK_ADDR_HI = 8'h0f; // Implemented high address bits
  localparam logic [7:0] MASK_DATA_HI = 8'h3f; // Implemented high data bits
  localparam logic [7:0] RST_BYTE = 8'h00; // Reset value of data registers
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125; // System clock rate
  localparam int WRITE_TIME_US = 5; // Default erase-and-write time
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ; // Cycles per write
  // Unlock sequencer states
  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_GOT1 = 3'b010,
    UNL_ARMED = 3'b100
  } unlock_state_t;
endpackage

// ### logic/nvm_indirect_access_ctrl.sv
// Indirect access controller for data EEPROM and program flash
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module nvm_indirect_access_ctrl
  import nvm_pkg::*;
#(
  parameter int WRITE_CYC = nvm_pkg::WRITE_CYCLES // Write cycle length in clocks
)(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic abort_reset, // Pulse: external or watchdog reset event
  input wire logic [4:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait
  output logic [7:0] ee_addr, // Data EEPROM address
  input wire logic [7:0] ee_rdata, // Data EEPROM read byte
  output logic ee_we, // Data EEPROM write pulse
  output logic [7:0] ee_wdata, // Data EEPROM write byte
  output logic [11:0] pm_addr, // Program memory word address
  input wire logic [13:0] pm_rdata, // Program memory word
  output logic pm_re, // Program memory read request
  output logic cpu_slot_steal, // Next CPU slot is taken by the read
  output logic irq // Write complete interrupt
);
  import nvm_pkg::*;
  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] addr_lo_q; // Address low
  logic [3:0] addr_hi_q; // Address high nibble
  logic [7:0] data_lo_q; // Data low
  logic [5:0] data_hi_q; // Data high
  logic sel_q; // Memory select
  logic write_enable_bit_q; // Write enable bit
  logic wr_q; // Write strobe
  logic rd_q; // Read strobe
  logic write_error_flag_q; // Write error flag
  logic wcf_q; // Write complete flag
  logic wcie_q; // Write complete irq enable
  logic pm_phase_q; // Program read in its stolen slot
  logic [31:0] wcnt_q; // Write timer
  unlock_state_t unl_q; // Unlock sequencer
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic req; // Request pending and not answered
  logic wr_hit; // Write taken this cycle
  logic [7:0] wb; // Write byte
  logic set_wr; // Write strobe accepted
  logic set_rd; // Read strobe accepted
  logic wr_done; // Write timer expiry
  assign req = (avs_read || avs_write) && avs_waitrequest;
  assign wr_hit = avs_write && avs_waitrequest;
  assign wb = avs_writedata[7:0];
  // accept strobe only when armed, enabled, data memory, idle
  assign set_wr = wr_hit && avs_address == OFS_CONTROL && wb[BIT_WR] && !wr_q && !rd_q
                  && unl_q == UNL_ARMED && write_enable_bit_q && !wb[BIT_SEL];
  // no read while a write runs
  assign set_rd = wr_hit && avs_address == OFS_CONTROL && wb[BIT_RD] && !wr_q && !rd_q;
  assign wr_done = wr_q && wcnt_q == 32'(WRITE_CYC - 1);
  // Answer one cycle after the request is seen
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~req;
  end
  // Read mux, registered at request time
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0;
    else if (avs_read && avs_waitrequest)
    begin
      // unimplemented bits and unlock port read zero
      unique case (avs_address)
        OFS_CONTROL: avs_readdata <= {24'h0, sel_q, 3'h0, write_error_flag_q, write_enable_bit_q, wr_q, rd_q};
        OFS_ADDR_LO: avs_readdata <= {24'h0, addr_lo_q};
        OFS_ADDR_HI: avs_readdata <= {28'h0, addr_hi_q};
        OFS_DATA_LO: avs_readdata <= {24'h0, data_lo_q};
        OFS_DATA_HI: avs_readdata <= {26'h0, data_hi_q};
        OFS_IRQ_EN: avs_readdata <= {24'h0, wcie_q, 7'h0};
        OFS_IRQ_FLAG: avs_readdata <= {24'h0, wcf_q, 7'h0};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
  // ****************************************************************
  // Address registers
  // ****************************************************************
  // Software writes only; kept on aborted write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      addr_lo_q <= RST_BYTE;
      addr_hi_q <= 4'h0;
    end
    else if (wr_hit && avs_address == OFS_ADDR_LO)
      addr_lo_q <= wb;
    else if (wr_hit && avs_address == OFS_ADDR_HI)
      addr_hi_q <= wb[3:0] & MASK_ADDR_HI[3:0];
  end
  // ****************************************************************
  // Unlock sequencer
  // ****************************************************************
  // any other bus write breaks the sequence
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      unl_q <= UNL_IDLE;
    else if (wr_hit)
    begin
      if (avs_address == OFS_UNLOCK && wb == KEY_FIRST)
        unl_q <= UNL_GOT1;
      else if (avs_address == OFS_UNLOCK && wb == KEY_SECOND && unl_q == UNL_GOT1)
        unl_q <= UNL_ARMED;
      else
        unl_q <= UNL_IDLE;
    end
  end
  // ****************************************************************
  // Control bits
  // ****************************************************************
  // Select and write enable are plain software bits
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sel_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
    end
    else if (wr_hit && avs_address == OFS_CONTROL)
    begin
      sel_q <= wb[BIT_SEL];
      write_enable_bit_q <= wb[BIT_WRITE_ENABLE_BIT];
    end
  end
  // Write strobe and timer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_q <= 1'b0;
      wcnt_q <= 32'h0;
    end
    // reset event cuts the write short
    else if (abort_reset)
    begin
      wr_q <= 1'b0;
      wcnt_q <= 32'h0;
    end
    else if (set_wr)
    begin
      wr_q <= 1'b1;
      wcnt_q <= 32'h0;
    end
    // runs to the end regardless of write enable
    else if (wr_q)
    begin
      if (wr_done)
        wr_q <= 1'b0;
      wcnt_q <= wcnt_q + 32'h1;
    end
  end
  // Error flag, software writable, set on abort
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      write_error_flag_q <= 1'b0;
    else if (abort_reset && wr_q)
      write_error_flag_q <= 1'b1;
    else if (wr_hit && avs_address == OFS_CONTROL)
      write_error_flag_q <= wb[BIT_WRITE_ERROR_FLAG];
  end
  // Read strobe: one cycle for data, two for program
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      pm_phase_q <= 1'b0;
    end
    else if (set_rd)
    begin
      rd_q <= 1'b1;
      pm_phase_q <= 1'b0;
    end
    // program read keeps strobe through stolen slot
    else if (rd_q && sel_q && !pm_phase_q)
      pm_phase_q <= 1'b1;
    else
    begin
      rd_q <= 1'b0;
      pm_phase_q <= 1'b0;
    end
  end
  // ****************************************************************
  // Data registers
  // ****************************************************************
  // Low data: read result or software write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      data_lo_q <= RST_BYTE;
    // data byte captured the cycle after the strobe
    else if (rd_q && !sel_q)
      data_lo_q <= ee_rdata;
    // program low byte after the stolen slot
    else if (rd_q && pm_phase_q)
      data_lo_q <= pm_rdata[7:0];
    else if (wr_hit && avs_address == OFS_DATA_LO)
      data_lo_q <= wb;
  end
  // High data
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      data_hi_q <= 6'h0;
    // upper six bits of the program word
    else if (rd_q && pm_phase_q)
      data_hi_q <= pm_rdata[13:8];
    else if (wr_hit && avs_address == OFS_DATA_HI)
      data_hi_q <= wb[5:0] & MASK_DATA_HI[5:0];
  end
  // ****************************************************************
  // Interrupt flag and enable
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wcf_q <= 1'b0;
      wcie_q <= 1'b0;
    end
    else
    begin
      // completion sets flag, set beats software clear
      if (wr_done && !abort_reset)
        wcf_q <= 1'b1;
      else if (wr_hit && avs_address == OFS_IRQ_FLAG)
        wcf_q <= wb[BIT_WCF];
      if (wr_hit && avs_address == OFS_IRQ_EN)
        wcie_q <= wb[BIT_WCF];
    end
  end
  // ****************************************************************
  // Memory side outputs and interrupt output
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ee_addr <= 8'h0;
      ee_wdata <= 8'h0;
      ee_we <= 1'b0;
      pm_addr <= 12'h0;
      pm_re <= 1'b0;
      cpu_slot_steal <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ee_addr <= addr_lo_q;
      ee_wdata <= data_lo_q;
      ee_we <= set_wr;
      // program address from both address registers
      pm_addr <= {addr_hi_q, addr_lo_q};
      pm_re <= set_rd && wb[BIT_SEL];
      cpu_slot_steal <= rd_q && sel_q && !pm_phase_q;
      irq <= wcf_q && wcie_q;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_write_enable_bit_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(write_enable_bit_q) |-> $past(wr_hit && avs_address == OFS_CONTROL))
    else $error("write enable cleared without software");
  a_wr_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(wr_q) |-> $past(write_enable_bit_q && unl_q == UNL_ARMED))
    else $error("write started without enable or unlock");
  a_wr_no_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(wr_q) |-> !sel_q)
    else $error("write started with program select");
  a_done_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_done && !abort_reset) |=> !wr_q && wcf_q)
    else $error("completion did not clear strobe and set flag");
  a_data_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (set_rd && !wb[BIT_SEL] && !sel_q) ##1 (rd_q && !sel_q) |=> data_lo_q == $past(ee_rdata))
    else $error("data read not captured");
  a_prog_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_q && sel_q && !pm_phase_q && !set_rd) |=> rd_q ##1 !rd_q)
    else $error("program read slot wrong");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq |-> $past(wcf_q && wcie_q))
    else $error("interrupt without enabled flag");
  a_err_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (abort_reset && wr_q) |=> write_error_flag_q && !wr_q)
    else $error("aborted write not flagged");
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_done);
  c_prog: cover property (@(posedge clk_sys) disable iff (!rst_n) pm_phase_q);
  c_abort: cover property (@(posedge clk_sys) disable iff (!rst_n) abort_reset && wr_q);
endmodule
`default_nettype wire

// ### testbench/nvm_mem_model.sv
// Behavioural model of the data EEPROM and program flash arrays
`timescale 1ns/1ps
`default_nettype none
module nvm_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic [7:0] ee_addr, // Data byte address
  output logic [7:0] ee_rdata, // Data byte read
  input wire logic ee_we, // Data write pulse
  input wire logic [7:0] ee_wdata, // Data byte to write
  input wire logic [11:0] pm_addr, // Program word address
  input wire logic pm_re, // Program read request
  output logic [13:0] pm_rdata // Program word read
);
  // ****************************************************************
  // Arrays and read paths
  // ****************************************************************
  logic [7:0] mem [256]; // Data bytes, seeded with address xor 5a
  logic [2:0] pm_live; // Cycles in which the word is driven
  logic [13:0] pm_word; // Word stored at the current address
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    pm_live = 3'h0;
  end
  // Data array answers at once from its address
  assign ee_rdata = mem[ee_addr];
  assign pm_word = {pm_addr, 2'b01};
  // Outside the read window the lines show the inverse, never a stale word
  assign pm_rdata = (pm_re || (|pm_live)) ? pm_word : ~pm_word;
  // Byte write and read window tracking
  always @(posedge clk_sys)
  begin
    if (ee_we === 1'b1)
      mem[ee_addr] <= ee_wdata;
    pm_live <= {pm_live[1:0], pm_re};
  end
endmodule
`default_nettype wire

// ### testbench/nvm_indirect_access_ctrl_tb_top.sv
// Self-checking testbench for the indirect memory access controller
`timescale 1ns/1ps
`default_nettype none
module nvm_indirect_access_ctrl_tb_top;
  import nvm_pkg::*;
  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  logic clk_sys, rst_n, abort_reset; // Clock, reset, abort pulse
  logic [4:0] avs_address; // Bus address
  logic avs_read, avs_write, avs_waitrequest; // Bus handshake
  logic [31:0] avs_writedata, avs_readdata, rdat; // Bus data and last read
  logic [7:0] ee_addr, ee_rdata, ee_wdata; // Data array port
  logic ee_we, pm_re, cpu_slot_steal, irq; // Strobes and interrupt
  logic [11:0] pm_addr; // Program address
  logic [13:0] pm_rdata; // Program word
  int n_errors, checks_done, n_we, n_steal; // Counters
  nvm_indirect_access_ctrl #(.WRITE_CYC(8)) nvm_indirect_access_ctrl_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .abort_reset(abort_reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ee_addr(ee_addr),
    .ee_rdata(ee_rdata), .ee_we(ee_we), .ee_wdata(ee_wdata), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .pm_re(pm_re), .cpu_slot_steal(cpu_slot_steal), .irq(irq));
  nvm_mem_model nvm_mem_model_i (.clk_sys(clk_sys), .ee_addr(ee_addr), .ee_rdata(ee_rdata),
    .ee_we(ee_we), .ee_wdata(ee_wdata), .pm_addr(pm_addr), .pm_re(pm_re),
    .pm_rdata(pm_rdata));
  // Clock at 125 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Counts array write pulses and stolen slots
  always @(posedge clk_sys)
  begin
    if (ee_we === 1'b1) n_we++;
    if (cpu_slot_steal === 1'b1) n_steal++;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // nothing else on the bus between the key bytes and the strobe
  task automatic start_write(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    wr(OFS_UNLOCK, k1);
    wr(OFS_UNLOCK, k2);
    wr(OFS_CONTROL, c);
  endtask
  // Polls the write strobe until it falls, bounded
  task automatic wait_done();
    int i;
    for (i = 0; i < 40; i++)
    begin
      rd(OFS_CONTROL);
      if (rdat[BIT_WR] === 1'b0) break;
    end
    if (i >= 40)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_map();
    logic [4:0] ofs [9];
    ofs = '{OFS_CONTROL, OFS_UNLOCK, OFS_ADDR_LO, OFS_ADDR_HI, OFS_DATA_LO, OFS_DATA_HI,
      OFS_IRQ_EN, OFS_IRQ_FLAG, 5'h02};
    // every register and the unmapped offset 02 read zero
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      check(rdat, 32'h00000000);
    end
    wr(OFS_ADDR_HI, 8'hff);
    wr(OFS_DATA_HI, 8'hff);
    wr(OFS_UNLOCK, 8'h55);
    rd(OFS_ADDR_HI);
    check(rdat, 32'h0000000f);
    rd(OFS_DATA_HI);
    check(rdat, 32'h0000003f);
    rd(OFS_UNLOCK);
    check(rdat, 32'h00000000);
    wr(OFS_CONTROL, 8'h70);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000000);
  endtask
  task automatic t_data_read();
    wr(OFS_ADDR_LO, 8'h3c);
    wr(OFS_CONTROL, 8'h01);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000066);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000000);
    wr(OFS_ADDR_LO, 8'h40);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000066);
    wr(OFS_DATA_LO, 8'h11);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000011);
  endtask
  task automatic t_prog_read();
    int s;
    s = n_steal;
    wr(OFS_ADDR_HI, 8'h0a);
    wr(OFS_ADDR_LO, 8'h5c);
    // the bus stays idle while the slot is taken
    wr(OFS_CONTROL, 8'h81);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000071);
    rd(OFS_DATA_HI);
    check(rdat, 32'h00000029);
    check(32'(n_steal - s), 32'h1);
    wr(OFS_CONTROL, 8'h00);
  endtask
  task automatic t_write();
    int w;
    w = n_we;
    // address and byte loaded once, before the first unlock
    wr(OFS_ADDR_LO, 8'h10);
    wr(OFS_DATA_LO, 8'h77);
    wr(OFS_IRQ_EN, 8'h80);
    start_write(KEY_FIRST, KEY_SECOND, 8'h02);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000000);
    wr(OFS_CONTROL, 8'h04);
    start_write(KEY_SECOND, KEY_FIRST, 8'h06);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000004);
    check(32'(n_we - w), 32'h0);
    start_write(KEY_FIRST, KEY_SECOND, 8'h06);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000006);
    wr(OFS_CONTROL, 8'h01);
    wait_done();
    check(rdat, 32'h00000000);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000077);
    check(32'(nvm_mem_model_i.mem[8'h10]), 32'h77);
    rd(OFS_IRQ_FLAG);
    check(rdat, 32'h00000080);
    check(32'(irq), 32'h1);
    wr(OFS_CONTROL, 8'h04);
    start_write(KEY_FIRST, KEY_SECOND, 8'h06);
    wait_done();
    check(rdat, 32'h00000004);
    wr(OFS_IRQ_FLAG, 8'h00);
    rd(OFS_IRQ_FLAG);
    check(rdat, 32'h00000000);
    check(32'(irq), 32'h0);
    check(32'(n_we - w), 32'h2);
  endtask
  task automatic t_prog_write_and_abort();
    int w;
    w = n_we;
    wr(OFS_CONTROL, 8'h84);
    start_write(KEY_FIRST, KEY_SECOND, 8'h86);
    rd(OFS_CONTROL);
    check(rdat, 32'h00000084);
    check(32'(n_we - w), 32'h0);
    wr(OFS_ADDR_LO, 8'h20);
    wr(OFS_DATA_LO, 8'h33);
    start_write(KEY_FIRST, KEY_SECOND, 8'h06);
    abort_reset <= 1'b1;
    @(posedge clk_sys);
    abort_reset <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_CONTROL);
    check(32'({rdat[BIT_WRITE_ERROR_FLAG], rdat[BIT_WR]}), 32'h2);
    rd(OFS_ADDR_LO);
    check(rdat, 32'h00000020);
    rd(OFS_DATA_LO);
    check(rdat, 32'h00000033);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {rst_n, abort_reset, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {n_errors, checks_done, n_we, n_steal} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_map();
    t_data_read();
    t_prog_read();
    t_write();
    t_prog_write_and_abort();
    stop_test();
  end
endmodule
`default_nettype wire
